// ### icdr_pkg.sv
package icdr_pkg;
    // Little-endian positions; operand bit n of the big-endian view is 31-n.
    localparam int unsigned ICDR_XLEN = 32;
    localparam int unsigned ICDR_SET_LSB = 5;
    localparam int unsigned ICDR_SET_W = 9;
    localparam int unsigned ICDR_WORD_LSB = 2;
    localparam int unsigned ICDR_WORD_W = 3;
    localparam int unsigned ICDR_TAG_W = 22;
    localparam int unsigned ICDR_WAYS = 2;
    // Tag word layout as returned in the debug data register.
    localparam int unsigned ICDR_TW_TAG_LSB = 10;
    localparam int unsigned ICDR_TW_VALID = 4;
    localparam int unsigned ICDR_TW_LRU = 0;
    localparam int unsigned ICDR_TW_RSV_HI_MSB = 9;
    localparam int unsigned ICDR_TW_RSV_HI_LSB = 5;
    localparam int unsigned ICDR_TW_RSV_LO_MSB = 3;
    localparam int unsigned ICDR_TW_RSV_LO_LSB = 1;
    // Cachability region taken from the top address bits.
    localparam int unsigned ICDR_REGION_LSB = 27;
    localparam int unsigned ICDR_REGION_W = 5;
    localparam logic [4:0] ICDR_REGION_TOP = 5'h1F;
    localparam logic ICDR_ARRAY_DATA = 1'b0;
    localparam logic ICDR_WAY_A = 1'b0;
    localparam logic [31:0] ICDR_DBG_RESET = 32'h0000_0000;

    typedef enum {ICDR_IDLE, ICDR_READ} icdr_state_e;

    typedef struct packed {
        logic valid;
        logic supervisor;
        logic base_field_zero;
        logic [31:0] base_operand_reg;
        logic [31:0] index_operand_reg;
        logic record_cr;
    } icdr_req_s;

    typedef struct packed {
        logic array_select;
        logic way_select;
    } icdr_cfg_s;

    typedef struct packed {
        logic done;
        logic cr0_undefined;
        logic dtlb_miss;
        logic priv_fault;
        logic data_storage_exc;
        logic dac_event;
        logic dac_as_load;
    } icdr_rsp_s;

    typedef struct packed {
        logic we;
        logic way;
        logic [ICDR_SET_W+ICDR_WORD_W-1:0] addr;
        logic [31:0] data;
    } icdr_fill_s;

    typedef struct packed {
        logic we;
        logic way;
        logic [ICDR_SET_W-1:0] set;
        logic [ICDR_TAG_W-1:0] tag;
        logic valid;
    } icdr_tagw_s;

    typedef struct packed {
        logic we;
        logic [ICDR_SET_W-1:0] set;
        logic lru;
    } icdr_lruw_s;
endpackage

// ### icdr_mem.sv
module icdr_mem #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned AW = 9
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [2**AW];

    if (WIDTH < 1 || AW < 1) begin : g_chk
        $error("icdr_mem: width and address width must be positive");
    end

    // Read data is registered so the array maps onto a synchronous RAM.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // icdr_mem

// ### icdr_top.sv
// Functional notes
// - Address is index plus base, or zero base.
// - Address bits 18 to 26 pick the set.
// - Data mode returns word picked by bits 27-29.
// - Way select zero reads way A, else B.
// - Array select one returns the tag entry.
// - Tag word holds tag, valid and LRU bits.
// - Result lands in the debug data register.
// - Only supervisor state may perform the read.
// - Translation follows data relocate, not instruction relocate.
// - Untranslated cachability comes from the instruction cache cachability register.
// - Exceptions are reported on the data side.
// - Data TLB miss may occur at the address.
// - Never raises a data storage exception.
// - Compared as load, yet no compare event.
// - Record bit leaves condition field zero undefined.
module icdr_top (
    input wire logic SYS_CLK,
    input wire logic RST,
    input icdr_pkg::icdr_req_s REQ,
    output logic READY,
    input icdr_pkg::icdr_cfg_s CORE_CACHE_CONFIG,
    input wire logic DATA_RELOCATE,
    input wire logic [31:0] ICACHE_CACHABILITY_REG,
    output logic XLATE_REQ,
    output logic XLATE_ON,
    output logic [31:0] XLATE_EA,
    input wire logic TLB_MISS,
    input wire logic TLB_CACHABLE,
    output logic CACHABLE,
    output logic [31:0] DAC_EA,
    output icdr_pkg::icdr_rsp_s RSP,
    output logic [31:0] ICACHE_DEBUG_DATA,
    input icdr_pkg::icdr_fill_s FILL,
    input icdr_pkg::icdr_tagw_s TAG_WR,
    input icdr_pkg::icdr_lruw_s LRU_WR
);
    import icdr_pkg::*;

    localparam int unsigned DAW = ICDR_SET_W + ICDR_WORD_W;
    localparam int unsigned TEW = ICDR_TAG_W + 1;

    icdr_state_e state_q, state_d;
    logic [31:0] dbg_q, dbg_d;
    logic arr_q, arr_d, way_q, way_d, rc_q, rc_d;
    logic cach_q, cach_d;
    logic [31:0] dac_q, dac_d;
    icdr_rsp_s rsp_q, rsp_d;
    logic [31:0] base_sel, effective_addr;
    logic [ICDR_SET_W-1:0] set_idx;
    logic [ICDR_WORD_W-1:0] word_idx;
    logic [ICDR_REGION_W-1:0] region;
    logic issue;
    logic [31:0] data_rd [ICDR_WAYS];
    logic [TEW-1:0] tag_rd [ICDR_WAYS];
    logic [0:0] lru_rd;
    logic [31:0] tag_word;

    assign base_sel = REQ.base_field_zero ? '0 : REQ.base_operand_reg;
    assign effective_addr = base_sel + REQ.index_operand_reg;
    assign set_idx = effective_addr[ICDR_SET_LSB +: ICDR_SET_W];
    assign word_idx = effective_addr[ICDR_WORD_LSB +: ICDR_WORD_W];
    assign region = effective_addr[ICDR_REGION_LSB +: ICDR_REGION_W];

    // The translation probe is combinational so a miss aborts in one cycle.
    // data relocate steers translation
    assign XLATE_REQ = (state_q == ICDR_IDLE) && REQ.valid && REQ.supervisor;
    assign XLATE_ON = DATA_RELOCATE;
    assign XLATE_EA = effective_addr;
    assign READY = (state_q == ICDR_IDLE);
    assign issue = XLATE_REQ && !(DATA_RELOCATE && TLB_MISS);

    // One data and one tag array per way; the debug path only reads them.
    for (genvar g = 0; g < ICDR_WAYS; g++) begin : g_way
        icdr_mem #(.WIDTH(32), .AW(DAW)) u_data (
            .clk(SYS_CLK),
            .wr_en(FILL.we && (FILL.way == 1'(g))),
            .wr_addr(FILL.addr),
            .wr_data(FILL.data),
            .rd_en(issue),
            .rd_addr({set_idx, word_idx}),
            .rd_data(data_rd[g])
        );
        icdr_mem #(.WIDTH(TEW), .AW(ICDR_SET_W)) u_tag (
            .clk(SYS_CLK),
            .wr_en(TAG_WR.we && (TAG_WR.way == 1'(g))),
            .wr_addr(TAG_WR.set),
            .wr_data({TAG_WR.tag, TAG_WR.valid}),
            .rd_en(issue),
            .rd_addr(set_idx),
            .rd_data(tag_rd[g])
        );
    end

    icdr_mem #(.WIDTH(1), .AW(ICDR_SET_W)) u_lru (
        .clk(SYS_CLK),
        .wr_en(LRU_WR.we),
        .wr_addr(LRU_WR.set),
        .wr_data(LRU_WR.lru),
        .rd_en(issue),
        .rd_addr(set_idx),
        .rd_data(lru_rd)
    );

    // tag word assembly, reserved bits zero
    always_comb begin
        tag_word = '0;
        tag_word[ICDR_TW_TAG_LSB +: ICDR_TAG_W] = tag_rd[way_q][TEW-1:1];
        tag_word[ICDR_TW_VALID] = tag_rd[way_q][0];
        tag_word[ICDR_TW_LRU] = lru_rd[0];
    end

    // Sequencer next state; a refused request leaves the arrays untouched.
    always_comb begin
        state_d = state_q;
        dbg_d = dbg_q;
        arr_d = arr_q;
        way_d = way_q;
        rc_d = rc_q;
        cach_d = cach_q;
        dac_d = dac_q;
        rsp_d = '0;
        case (state_q)
            ICDR_IDLE: begin
                if (REQ.valid && !REQ.supervisor) begin
                    rsp_d.priv_fault = 1'b1;
                end else if (REQ.valid && DATA_RELOCATE && TLB_MISS) begin
                    rsp_d.dtlb_miss = 1'b1;
                end else if (issue) begin
                    state_d = ICDR_READ;
                    arr_d = CORE_CACHE_CONFIG.array_select;
                    way_d = CORE_CACHE_CONFIG.way_select;
                    rc_d = REQ.record_cr;
                    dac_d = effective_addr;
                    rsp_d.dac_as_load = 1'b1;
                    cach_d = DATA_RELOCATE ? TLB_CACHABLE
                        : ICACHE_CACHABILITY_REG[ICDR_REGION_TOP - region];
                end
            end
            ICDR_READ: begin
                if (arr_q != ICDR_ARRAY_DATA) begin
                    dbg_d = tag_word;
                end else begin
                    dbg_d = data_rd[way_q];
                end
                rsp_d.done = 1'b1;
                rsp_d.cr0_undefined = rc_q;
                state_d = ICDR_IDLE;
            end
            default: begin
                state_d = ICDR_IDLE;
            end
        endcase
        rsp_d.data_storage_exc = 1'b0;
        rsp_d.dac_event = 1'b0;
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q <= ICDR_IDLE;
            dbg_q <= ICDR_DBG_RESET;
            arr_q <= 1'b0;
            way_q <= 1'b0;
            rc_q <= 1'b0;
            cach_q <= 1'b0;
            dac_q <= '0;
            rsp_q <= '0;
        end else begin
            state_q <= state_d;
            dbg_q <= dbg_d;
            arr_q <= arr_d;
            way_q <= way_d;
            rc_q <= rc_d;
            cach_q <= cach_d;
            dac_q <= dac_d;
            rsp_q <= rsp_d;
        end
    end

    assign ICACHE_DEBUG_DATA = dbg_q;
    assign CACHABLE = cach_q;
    assign DAC_EA = dac_q;
    assign RSP = rsp_q;

    sequence s_issue;
        XLATE_REQ && !(DATA_RELOCATE && TLB_MISS);
    endsequence

    sequence s_finish;
        (state_q == ICDR_READ) ##1 RSP.done;
    endsequence

    property p_ea;
        @(posedge SYS_CLK) disable iff (RST)
        s_issue |=> DAC_EA == $past(base_sel) + $past(REQ.index_operand_reg);
    endproperty
    a_ea: assert property (p_ea) else $error("address sum wrong");

    property p_priv;
        @(posedge SYS_CLK) disable iff (RST)
        READY && REQ.valid && !REQ.supervisor
            |=> RSP.priv_fault ##1 !RSP.done;
    endproperty
    a_priv: assert property (p_priv) else $error("user read not refused");

    property p_tlb;
        @(posedge SYS_CLK) disable iff (RST)
        READY && REQ.valid && REQ.supervisor && DATA_RELOCATE && TLB_MISS
            |=> RSP.dtlb_miss && $stable(ICACHE_DEBUG_DATA) ##1 !RSP.done;
    endproperty
    a_tlb: assert property (p_tlb) else $error("tlb miss mishandled");

    property p_done;
        @(posedge SYS_CLK) disable iff (RST)
        s_issue |=> s_finish;
    endproperty
    a_done: assert property (p_done) else $error("read did not finish");

    property p_data_way;
        @(posedge SYS_CLK) disable iff (RST)
        RSP.done && $past(arr_q) == ICDR_ARRAY_DATA
            |-> ICACHE_DEBUG_DATA == $past(data_rd[way_q]);
    endproperty
    a_data_way: assert property (p_data_way) else $error("wrong data word");

    property p_tag_rsv;
        @(posedge SYS_CLK) disable iff (RST)
        RSP.done && $past(arr_q) != ICDR_ARRAY_DATA
            |-> ICACHE_DEBUG_DATA[ICDR_TW_RSV_HI_MSB:ICDR_TW_RSV_HI_LSB] == '0
                && ICACHE_DEBUG_DATA[ICDR_TW_RSV_LO_MSB:ICDR_TW_RSV_LO_LSB]
                == '0;
    endproperty
    a_tag_rsv: assert property (p_tag_rsv) else $error("reserved bits set");

    property p_no_exc;
        @(posedge SYS_CLK) disable iff (RST)
        !RSP.data_storage_exc && !RSP.dac_event;
    endproperty
    a_no_exc: assert property (p_no_exc) else $error("forbidden event");

    property p_load;
        @(posedge SYS_CLK) disable iff (RST)
        s_issue |=> RSP.dac_as_load ##1 !RSP.dac_as_load;
    endproperty
    a_load: assert property (p_load) else $error("not compared as load");

    property p_cach;
        @(posedge SYS_CLK) disable iff (RST)
        s_issue ##0 !DATA_RELOCATE |=> CACHABLE
            == $past(ICACHE_CACHABILITY_REG[ICDR_REGION_TOP - region]);
    endproperty
    a_cach: assert property (p_cach) else $error("cachability source");

    property p_cr0;
        @(posedge SYS_CLK) disable iff (RST)
        s_issue ##0 REQ.record_cr |-> ##2 RSP.cr0_undefined;
    endproperty
    a_cr0: assert property (p_cr0) else $error("cr0 flag missing");
endmodule // icdr_top

// ### icdr_pipe_model.sv
module icdr_pipe_model (
    input wire logic clk,
    input wire logic xlate_req,
    input wire logic [31:0] xlate_ea,
    input wire logic [19:0] miss_page,
    input wire logic done,
    input wire logic [31:0] debug_data,
    output logic tlb_miss,
    output logic tlb_cachable,
    output logic [31:0] gpr_q
);
    logic [31:0] gpr_d;

    // Lookup answers follow the clock outside a lookup, so a design that
    // samples them at the wrong moment sees a changing value, not a held one.
    // sync before move
    always_comb begin
        tlb_miss = xlate_req ? (xlate_ea[31:12] == miss_page) : clk;
        tlb_cachable = xlate_req ? xlate_ea[12] : ~clk;
        gpr_d = done ? debug_data : gpr_q; // Move waits for completion.
    end

    // Register copy of the debug data, as a move-from would make it.
    always_ff @(posedge clk) begin
        gpr_q <= gpr_d;
    end
endmodule // icdr_pipe_model

// ### icdr_top_tb.sv
module icdr_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import icdr_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    icdr_req_s req;
    icdr_cfg_s cfg;
    icdr_fill_s fill;
    icdr_tagw_s tw;
    icdr_lruw_s lw;
    icdr_rsp_s rsp;
    logic dr, ready, xreq, xon, miss, tcach, cach;
    logic [31:0] ccreg, xea, dac_ea, dbg, gpr;
    logic [19:0] miss_page;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    // Clock of 100 ns period.
    always #50 sys_clk = ~sys_clk;

    icdr_top icdr_top_inst (.SYS_CLK(sys_clk), .RST(rst), .REQ(req),
        .READY(ready), .CORE_CACHE_CONFIG(cfg), .DATA_RELOCATE(dr),
        .ICACHE_CACHABILITY_REG(ccreg), .XLATE_REQ(xreq), .XLATE_ON(xon),
        .XLATE_EA(xea), .TLB_MISS(miss), .TLB_CACHABLE(tcach),
        .CACHABLE(cach), .DAC_EA(dac_ea), .RSP(rsp),
        .ICACHE_DEBUG_DATA(dbg), .FILL(fill), .TAG_WR(tw), .LRU_WR(lw));

    icdr_pipe_model icdr_pipe_model_inst (.clk(sys_clk), .xlate_req(xreq),
        .xlate_ea(xea), .miss_page(miss_page), .done(rsp.done),
        .debug_data(dbg), .tlb_miss(miss), .tlb_cachable(tcach),
        .gpr_q(gpr));

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Array contents are a function of position, so any misrouted way,
    // set or word shows up as a wrong value.
    function automatic logic [31:0] fdat(logic w, logic [8:0] s,
                                         logic [2:0] d);
        return {8'h5A, 4'h0, w, 4'h0, 3'h0, s, d};
    endfunction

    function automatic logic [31:0] ftw(logic w, logic [8:0] s);
        return {w, 3'h0, s, 9'h1A5, 5'h00, s[0] ^ w, 3'h0, s[1]};
    endfunction

    // One debug read; an accepted request stays valid, with its index operand inverted, while the block is busy.
    task automatic rd(input logic sup, input logic bz, input logic rec,
                      input logic as, input logic ws,
                      input logic [31:0] base, input logic [31:0] idx);
        logic [31:0] ea, old, exp;
        logic ok, c;
        ea = (bz ? 32'h0 : base) + idx;
        ok = sup & ~(dr & (ea[31:12] == miss_page));
        old = dbg;
        exp = as ? ftw(ws, ea[13:5]) : fdat(ws, ea[13:5], ea[4:2]);
        c = dr ? ea[12] : ccreg[5'd31 - ea[31:27]];
        req = '{1'b1, sup, bz, base, idx, rec};
        cfg = '{as, ws};
        // Let the probe outputs settle before looking at them.
        #1;
        chk(xreq, sup);
        chk(xea, ea);
        chk(xon, dr);
        @(negedge sys_clk);
        req.valid = ok;
        req.index_operand_reg = ~idx;
        chk(rsp.priv_fault, !sup);
        chk(rsp.dtlb_miss, sup & ~ok);
        chk(rsp.dac_as_load, ok);
        chk(rsp.data_storage_exc, 1'b0);
        chk(rsp.dac_event, 1'b0);
        if (ok) begin
            chk(ready, 1'b0);
            chk(dac_ea, ea);
            chk(cach, c);
        end
        @(negedge sys_clk);
        req.valid = 1'b0;
        chk(rsp.done, ok);
        chk(rsp.cr0_undefined, ok & rec);
        chk(dbg, ok ? exp : old);
        chk(ready, 1'b1);
        @(negedge sys_clk);
        if (ok)
            chk(gpr, exp);
    endtask

    // Cuts a hang short.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // Load the arrays, then read every way and array with varied addresses.
    initial begin
        req = '0;
        cfg = '0;
        fill = '0;
        tw = '0;
        lw = '0;
        dr = 1'b0;
        miss_page = 20'h00000;
        ccreg = 32'hA5C3_0F69;
        repeat (16) @(negedge sys_clk);
        // Values that reset must leave behind.
        chk(dbg, ICDR_DBG_RESET);
        chk(ready, 1'b1);
        chk(rsp, 32'h0000_0000);
        chk(cach, 1'b0);
        chk(dac_ea, 32'h0000_0000);
        rst = 1'b0;
        for (int w = 0; w < 2; w++) begin
            for (int s = 0; s < 512; s++) begin
                for (int d = 0; d < 8; d++) begin
                    fill = '{1'b1, w[0], 12'(s * 8 + d),
                             fdat(w[0], s[8:0], d[2:0])};
                    tw = '{d == 0, w[0], s[8:0],
                           22'(ftw(w[0], s[8:0]) >> 10),
                           s[0] ^ w[0]};
                    lw = '{w == 0 && d == 0, s[8:0], s[1]};
                    @(negedge sys_clk);
                end
            end
        end
        fill = '0;
        tw = '0;
        lw = '0;
        for (int k = 0; k < 32; k++) begin
            rd(1'b1, k[2], k[0], k[1], k[2] ^ k[3], 32'h1111_1FE4 * k,
               32'h0000_001C);
        end
        rd(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 32'h0000_3000, 32'h0000_0004);
        dr = 1'b1;
        miss_page = 20'h12345;
        rd(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 32'h1234_5000, 32'h0000_0FE0);
        rd(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 32'h1234_5000, 32'h0000_1FFC);
        rd(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_0000, 32'h0000_3FE0);
        summarize();
    end
endmodule // icdr_top_tb
